// ### design/bps_consts.svh
// timing counts and field constants for the buck protection sequencer
// assumes a 250 MHz reference clock and a 4 us internal tick
`ifndef BPS_CONSTS_SVH
`define BPS_CONSTS_SVH
`define BPS_CLK_MHZ 250
`define BPS_TICK_NS 4000
`define BPS_TICK_CYC ((`BPS_TICK_NS * `BPS_CLK_MHZ) / 1000)
`define BPS_CAL_US 250
`define BPS_CAL_TICKS (`BPS_CAL_US / 4)
`define BPS_UV_DLY_US 1000
`define BPS_UV_DLY_TICKS (`BPS_UV_DLY_US / 4)
`define BPS_UV_EN_US 1500
`define BPS_UV_EN_TICKS (`BPS_UV_EN_US / 4)
`define BPS_PG_RISE_US 1000
`define BPS_PG_RISE_TICKS (`BPS_PG_RISE_US / 4)
`define BPS_PG_FALL_NS 2000
`define BPS_PG_FALL_CYC ((`BPS_PG_FALL_NS * `BPS_CLK_MHZ) / 1000)
`define BPS_HIC_OFFSET 257
`define BPS_HIC_REPEAT 7
`define BPS_HIC_N_BASE 8
`define BPS_SS_RAMP_BASE_US 700
`define BPS_DAC_FULL 10'h3FF
`define BPS_FREQ_OPEN 3'h3
`endif

// ### design/bps_pkg.sv
// types shared by the buck protection sequencer
// no assumptions beyond a single clock domain
package bps_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_CAL,
    ST_RAMP,
    ST_RUN,
    ST_OV_LATCH,
    ST_HICCUP
  } bps_state_e;
endpackage

// ### design/bps_sequencer.sv
// supervisory sequencer for a synchronous buck stage: startup, protection, mode
// assumes asynchronous comparator flags, one 250 MHz clock, active-low async reset
// Summary of operation
// (R1) hold off state while valley current trips
// (R2) repeat shutdown and restart during overload
// (R3) wait interval is (2^n+257) ticks
// (R4) hiccup delay lasts seven wait intervals
// (R5) undervoltage for 1ms latches both drivers off
// (R6) restart after hiccup following undervoltage latch
// (R7) undervoltage armed 1.5ms after soft-start ends
// (R8) overvoltage: high side off, low side on
// (R9) undervoltage during overvoltage latch: off, hiccup
// (R10) overvoltage present keeps drivers off, no restart
// (R11) supply lockout shuts off, restarts unlatched
// (R12) over-temperature shuts off, resumes unlatched
// (R13) enable rise begins startup sequence
// (R14) 250us calibration stores frequency code, no switching
// (R15) calibration latches soft-start selection from mode pin
// (R16) reference code ramps steadily from zero to full
// (R17) four mode resistances select 0.7-5.6ms ramps
// (R18) mode above 1.3V selects forced continuous
// (R19) board ties mode pin through resistor to power-good
// (R20) skip mode: low side off at zero current
// (R21) skip mode: fixed on-time, restart at reference
// (R22) forced continuous never applies zero-current turn-off
// (R23) power-good armed only after soft-start finishes
// (R24) power-good rises 1ms after entering window
// (R25) power-good falls about 2us after leaving window
// (R26) synchronise flags except pwm set and on-time end; time from 4us tick, except power-good fall counted in clocks
`timescale 1ns/10ps
`default_nettype none
`include "bps_consts.svh"
module bps_sequencer #(
  parameter int DAC_W = 10,
  parameter int UV_DLY_TICKS = `BPS_UV_DLY_TICKS,
  parameter int UV_EN_TICKS = `BPS_UV_EN_TICKS,
  parameter int PG_RISE_TICKS = `BPS_PG_RISE_TICKS,
  parameter int CAL_TICKS = `BPS_CAL_TICKS,
  parameter int HIC_SCALE_SHIFT = 0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_supply_lockout,
  input wire logic i_over_temp,
  input wire logic i_fb_under,
  input wire logic i_fb_over,
  input wire logic i_pg_window_in,
  input wire logic i_pg_window_out,
  input wire logic i_overcurrent_limit,
  input wire logic i_pwm_set,
  input wire logic i_on_time_done,
  input wire logic i_zero_cross,
  input wire logic i_mode_high,
  input wire logic [1:0] i_mode_res_code,
  input wire logic [2:0] i_freq_res_code,
  output logic o_high_side_on,
  output logic o_low_side_on,
  output logic [DAC_W-1:0] o_ref_dac,
  output logic [2:0] o_freq_code,
  output logic [1:0] o_soft_start_sel,
  output logic o_forced_continuous_mode,
  output logic o_power_good_output,
  output logic o_power_good_oe,
  output logic o_calibrating,
  output logic o_hiccup
);
  localparam int NSYNC = 10;

  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [4:0] res1;
    logic [4:0] res2;
    bps_pkg::bps_state_e state;
    logic [12:0] tcnt;
    logic [2:0] hic_rep;
    logic [9:0] uv_cnt;
    logic uv_armed;
    logic [9:0] uv_arm_cnt;
    logic ss_done;
    logic [9:0] pg_rise_cnt;
    logic [8:0] pg_fall_cnt;
    logic pg;
    logic forced_continuous_mode;
    logic [2:0] freq;
    logic [1:0] ss_sel;
    logic [DAC_W-1:0] dac;
    logic hs;
    logic ls;
  } bps_seq_s;

  bps_seq_s cur;
  bps_seq_s next_cur;
  logic tick;

  bps_tick_timer #(
    .TICK_CYC(`BPS_TICK_CYC)
  ) u_tick (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  // ticks for one hiccup wait interval at the selected soft-start
  function automatic logic [12:0] hic_wait(input logic [1:0] sel);
    logic [12:0] w;
    w = (13'h0001 << (`BPS_HIC_N_BASE + sel)) + 13'(`BPS_HIC_OFFSET);
    hic_wait = w >> HIC_SCALE_SHIFT;
  endfunction

  // ticks for the whole dac ramp, so the full ramp spans 0.7 ms scaled by 2^sel
  function automatic logic [12:0] ramp_ticks(input logic [1:0] sel);
    ramp_ticks = 13'(((`BPS_SS_RAMP_BASE_US / 4) << sel) >> HIC_SCALE_SHIFT);
  endfunction

  // states in which the switching cell and the mode comparator are live
  function automatic logic switching_state(input bps_pkg::bps_state_e st);
    switching_state = (st == bps_pkg::ST_RAMP) || (st == bps_pkg::ST_RUN);
  endfunction

  logic en_s, lock_s, temp_s, uv_s, ov_s, pgin_s, pgout_s, oc_s, zc_s, mode_s;
  logic fault_soft;
  logic [12:0] ramp_acc;

  assign en_s = cur.sync2[0]; // R26
  assign lock_s = cur.sync2[1];
  assign temp_s = cur.sync2[2];
  assign uv_s = cur.sync2[3];
  assign ov_s = cur.sync2[4];
  assign pgin_s = cur.sync2[5];
  assign pgout_s = cur.sync2[6];
  assign oc_s = cur.sync2[7];
  assign zc_s = cur.sync2[8];
  assign mode_s = cur.sync2[9];
  assign fault_soft = !en_s || lock_s || temp_s; // R11 R12
  assign ramp_acc = ramp_ticks(cur.ss_sel);

  always_comb begin
    next_cur = cur;
    next_cur.sync1 = {i_mode_high, i_zero_cross, i_overcurrent_limit, i_pg_window_out,
                      i_pg_window_in, i_fb_over, i_fb_under, i_over_temp, i_supply_lockout, i_enable};
    next_cur.sync2 = cur.sync1; // R26
    next_cur.res1 = {i_mode_res_code, i_freq_res_code};
    next_cur.res2 = cur.res1;

    // switching cell: high side on by pwm set, off at on-time end
    if (switching_state(cur.state)) begin
      if (cur.hs) begin
        if (i_on_time_done) begin
          next_cur.hs = 1'b0;
          next_cur.ls = 1'b1;
        end
      end else begin
        if (i_pwm_set && !oc_s) begin // R1 R21
          next_cur.hs = 1'b1;
          next_cur.ls = 1'b0;
        end else if (zc_s && !cur.forced_continuous_mode) begin
          next_cur.ls = 1'b0; // R20 R22
        end
      end
    end

    // power-good window filter
    if (cur.ss_done && (cur.state == bps_pkg::ST_RUN)) begin // R23
      if (pgout_s) begin
        next_cur.pg_rise_cnt = '0;
        if (cur.pg_fall_cnt == 9'(`BPS_PG_FALL_CYC - 1)) begin
          next_cur.pg = 1'b0; // R25
        end else begin
          next_cur.pg_fall_cnt = cur.pg_fall_cnt + 9'h001;
        end
      end else begin
        next_cur.pg_fall_cnt = '0;
        if (pgin_s && !cur.pg && tick) begin
          if (cur.pg_rise_cnt == 10'(PG_RISE_TICKS - 1)) begin
            next_cur.pg = 1'b1; // R24
          end else begin
            next_cur.pg_rise_cnt = cur.pg_rise_cnt + 10'h001;
          end
        end else if (!pgin_s) begin
          next_cur.pg_rise_cnt = '0;
        end
      end
    end else begin
      next_cur.pg = 1'b0;
      next_cur.pg_rise_cnt = '0;
      next_cur.pg_fall_cnt = '0;
    end

    // mode comparator is read only once soft-start has begun
    if (switching_state(cur.state)) begin
      next_cur.forced_continuous_mode = mode_s; // R18
    end else begin
      next_cur.forced_continuous_mode = 1'b0;
    end

    // undervoltage arming after soft-start completes
    if (cur.state == bps_pkg::ST_RUN && !cur.uv_armed && tick) begin
      if (cur.uv_arm_cnt == 10'(UV_EN_TICKS - 1)) begin
        next_cur.uv_armed = 1'b1; // R7
      end else begin
        next_cur.uv_arm_cnt = cur.uv_arm_cnt + 10'h001;
      end
    end

    // undervoltage delay counter
    if (cur.uv_armed && uv_s) begin
      if (tick) begin
        next_cur.uv_cnt = cur.uv_cnt + 10'h001;
      end
    end else begin
      next_cur.uv_cnt = '0;
    end

    case (cur.state)
      bps_pkg::ST_OFF: begin
        next_cur.hs = 1'b0;
        next_cur.ls = 1'b0;
        next_cur.dac = '0;
        next_cur.tcnt = '0;
        next_cur.ss_done = 1'b0;
        next_cur.uv_armed = 1'b0;
        next_cur.uv_arm_cnt = '0;
        if (!fault_soft && !ov_s) begin // R13 R11 R12
          next_cur.state = bps_pkg::ST_CAL;
        end
      end
      bps_pkg::ST_CAL: begin
        next_cur.hs = 1'b0; // R14
        next_cur.ls = 1'b0;
        if (fault_soft) begin
          next_cur.state = bps_pkg::ST_OFF;
        end else if (tick) begin
          if (cur.tcnt == 13'(CAL_TICKS - 1)) begin
            next_cur.freq = cur.res2[2:0]; // R14
            next_cur.ss_sel = cur.res2[4:3]; // R15 R17
            next_cur.tcnt = '0;
            next_cur.state = bps_pkg::ST_RAMP;
          end else begin
            next_cur.tcnt = cur.tcnt + 13'h0001;
          end
        end
      end
      bps_pkg::ST_RAMP: begin
        if (fault_soft) begin
          next_cur.state = bps_pkg::ST_OFF;
        end else if (ov_s) begin
          next_cur.state = bps_pkg::ST_OV_LATCH;
        end else if (tick) begin
          // set the reference each tick to the elapsed fraction of full scale for a straight ramp
          if (cur.tcnt >= ramp_acc - 13'h0001) begin
            next_cur.dac = DAC_W'(`BPS_DAC_FULL); // R16
            next_cur.ss_done = 1'b1;
            next_cur.tcnt = '0;
            next_cur.state = bps_pkg::ST_RUN;
          end else begin
            next_cur.tcnt = cur.tcnt + 13'h0001;
            next_cur.dac = DAC_W'((32'(cur.tcnt + 13'h0001) * 32'(`BPS_DAC_FULL)) / 32'(ramp_acc)); // R16
          end
        end
      end
      bps_pkg::ST_RUN: begin
        if (fault_soft) begin
          next_cur.state = bps_pkg::ST_OFF;
        end else if (ov_s) begin
          next_cur.state = bps_pkg::ST_OV_LATCH;
        // an overload sags the output, so the run ends here and retries after the hiccup
        end else if (cur.uv_cnt == 10'(UV_DLY_TICKS)) begin
          next_cur.hs = 1'b0; // R5
          next_cur.ls = 1'b0;
          next_cur.tcnt = '0;
          next_cur.hic_rep = '0;
          next_cur.state = bps_pkg::ST_HICCUP; // R2
        end
      end
      bps_pkg::ST_OV_LATCH: begin
        next_cur.hs = 1'b0; // R8
        next_cur.ls = 1'b1;
        next_cur.pg = 1'b0;
        // the low side pulls the output down until it sags to the undervoltage level
        if (fault_soft) begin
          next_cur.state = bps_pkg::ST_OFF;
        end else if (uv_s) begin
          next_cur.ls = 1'b0; // R9
          next_cur.tcnt = '0;
          next_cur.hic_rep = '0;
          next_cur.state = bps_pkg::ST_HICCUP;
        end
      end
      bps_pkg::ST_HICCUP: begin
        next_cur.hs = 1'b0;
        next_cur.ls = 1'b0;
        next_cur.dac = '0;
        next_cur.ss_done = 1'b0;
        next_cur.uv_armed = 1'b0;
        next_cur.uv_arm_cnt = '0;
        if (fault_soft) begin
          next_cur.state = bps_pkg::ST_OFF;
        end else if (tick) begin
          if (cur.tcnt == hic_wait(cur.ss_sel) - 13'h0001) begin // R3
            next_cur.tcnt = '0;
            if (cur.hic_rep == 3'(`BPS_HIC_REPEAT - 1)) begin // R4
              // a lingering overvoltage holds the restart back for another interval
              if (!ov_s) begin // R10
                next_cur.state = bps_pkg::ST_CAL; // R6 R2
              end
            end else begin
              next_cur.hic_rep = cur.hic_rep + 3'h1;
            end
          end else begin
            next_cur.tcnt = cur.tcnt + 13'h0001;
          end
        end
      end
      default: begin
        next_cur.state = bps_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur <= '0;
      // the stored frequency reads as the open-pin code until calibrated
      cur.freq <= `BPS_FREQ_OPEN;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_high_side_on = cur.hs;
  assign o_low_side_on = cur.ls;
  assign o_ref_dac = cur.dac;
  assign o_freq_code = cur.freq;
  assign o_soft_start_sel = cur.ss_sel;
  assign o_forced_continuous_mode = cur.forced_continuous_mode;
  assign o_power_good_output = 1'b0;
  assign o_power_good_oe = !cur.pg;
  assign o_calibrating = (cur.state == bps_pkg::ST_CAL);
  assign o_hiccup = (cur.state == bps_pkg::ST_HICCUP);
endmodule
`default_nettype wire

// ### design/bps_tick_timer.sv
// free running 4 us tick generator with a one-cycle strobe
// assumes one reference clock; period set by caller, count width fixed at 12 bits
`timescale 1ns/10ps
`default_nettype none
`include "bps_consts.svh"
module bps_tick_timer #(
  parameter int TICK_CYC = `BPS_TICK_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  output logic o_tick
);
  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
  } bps_tick_s;
  bps_tick_s cur;
  bps_tick_s next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    if (cur.cnt == 12'(TICK_CYC - 1)) begin
      next_cur.cnt = 12'h000;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.cnt = cur.cnt + 12'h001;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_tick = cur.tick;
endmodule
`default_nettype wire

// ### test/bps_analog_model.sv
// behavioural far side: on-time one-shot, pwm comparator, mode pin
// assumes the sequencer's high-side command and power-good enable
`timescale 1ns/10ps
`default_nettype none
module bps_analog_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_high_side_on,
  input wire logic i_power_good_oe,
  input wire logic i_forced_continuous_mode_wired,
  output logic o_pwm_set,
  output logic o_on_time_done,
  output logic o_mode_high
);
  logic [4:0] off_cnt;
  logic [2:0] on_cnt;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      off_cnt <= 5'h00;
      on_cnt <= 3'h0;
    end else begin
      off_cnt <= i_high_side_on ? 5'h00 : off_cnt + 5'h01;
      on_cnt <= i_high_side_on ? on_cnt + 3'h1 : 3'h0;
    end
  end
  assign o_on_time_done = i_high_side_on && on_cnt == 3'h7;
  assign o_pwm_set = !i_high_side_on && off_cnt == 5'h1F;
  // mode resistor tied to the power-good pin
  assign o_mode_high = i_forced_continuous_mode_wired && !i_power_good_oe;
endmodule
`default_nettype wire

// ### test/bps_sequencer_sva.sv
// port assertions for the buck protection sequencer
// bound from the testbench; one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module bps_sequencer_sva #(
  parameter int DAC_W = 10,
  parameter int CAL_TICKS = 62
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_supply_lockout,
  input wire logic i_over_temp,
  input wire logic i_fb_under,
  input wire logic i_fb_over,
  input wire logic i_pg_window_out,
  input wire logic i_overcurrent_limit,
  input wire logic i_zero_cross,
  input wire logic o_high_side_on,
  input wire logic o_low_side_on,
  input wire logic [DAC_W-1:0] o_ref_dac,
  input wire logic o_forced_continuous_mode,
  input wire logic o_power_good_output,
  input wire logic o_power_good_oe,
  input wire logic o_calibrating,
  input wire logic o_hiccup
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] cal_cnt;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) cal_cnt <= 16'h0000;
    else cal_cnt <= o_calibrating ? cal_cnt + 16'h0001 : 16'h0000;
  end
  ocl_hold_off_a: assert property ((i_overcurrent_limit && !o_high_side_on)[*4] |=> !o_high_side_on)
    else $error("high side on during overcurrent");
  cal_quiet_a: assert property (o_calibrating |-> !o_high_side_on && !o_low_side_on)
    else $error("switching during calibration");
  cal_length_a: assert property ($fell(o_calibrating) && i_enable && !i_supply_lockout && !i_over_temp
    |-> cal_cnt >= (CAL_TICKS - 1) * 1000 && cal_cnt <= CAL_TICKS * 1000 + 4) else $error("calibration length");
  hiccup_off_a: assert property (o_hiccup |-> !o_high_side_on && !o_low_side_on)
    else $error("driver on in hiccup");
  ov_high_off_a: assert property (i_fb_over[*4] |=> !o_high_side_on)
    else $error("high side on in overvoltage");
  ov_uv_off_a: assert property ((i_fb_over && i_fb_under)[*8] |=> !o_high_side_on && !o_low_side_on)
    else $error("driver on after overvoltage and undervoltage");
  lockout_off_a: assert property (i_supply_lockout[*4] |=> !o_high_side_on && !o_low_side_on && !o_calibrating)
    else $error("active during lockout");
  temp_off_a: assert property (i_over_temp[*4] |=> !o_high_side_on && !o_low_side_on && !o_calibrating)
    else $error("active during over-temperature");
  pg_idle_a: assert property ((o_calibrating || o_hiccup)[*2] |-> o_power_good_oe && !o_power_good_output)
    else $error("power-good released early");
  pg_fall_a: assert property ($rose(i_pg_window_out) && !o_power_good_oe |-> ##[490:510] o_power_good_oe)
    else $error("power-good fall delay");
  dac_ramp_a: assert property (o_ref_dac != $past(o_ref_dac) |-> o_ref_dac > $past(o_ref_dac) || o_ref_dac == '0)
    else $error("reference code stepped down");
  skip_zero_a: assert property ((!o_forced_continuous_mode && i_zero_cross && !i_fb_over
    && !o_high_side_on)[*4] |=> !o_low_side_on) else $error("low side on at zero current in skip");
endmodule
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the buck protection sequencer
// shortened tick counts; far side from bps_analog_model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, lock = 1'b0, temp = 1'b0, fbu = 1'b0, fbo = 1'b0;
  logic win_in = 1'b0, win_out = 1'b0, overcurrent_limit = 1'b0, zc = 1'b0, wired = 1'b0, pwm, otd, mh;
  logic [1:0] mcode = 2'h0;
  logic [2:0] fcode = 3'h5;
  logic hs, ls, fcm, pgo, pgoe, cal, hic, lp;
  logic [9:0] dac;
  logic [2:0] fq;
  logic [1:0] ss;
  logic [4:0] sig;
  int n_errors = 0, n_checks = 0, k, t0, t1, n_ls;
  always #2 clk = ~clk;
  assign sig = {pgoe, hs, dac == 10'h3FF, hic, cal};
  bps_sequencer #(.UV_DLY_TICKS(2), .UV_EN_TICKS(2), .PG_RISE_TICKS(2), .CAL_TICKS(2), .HIC_SCALE_SHIFT(6))
  i_bps_sequencer (.i_ref_clk(clk), .i_rst_n(rst_n), .i_enable(en), .i_supply_lockout(lock), .i_over_temp(temp),
    .i_fb_under(fbu), .i_fb_over(fbo), .i_pg_window_in(win_in), .i_pg_window_out(win_out),
    .i_overcurrent_limit(overcurrent_limit), .i_pwm_set(pwm), .i_on_time_done(otd), .i_zero_cross(zc), .i_mode_high(mh),
    .i_mode_res_code(mcode), .i_freq_res_code(fcode), .o_high_side_on(hs), .o_low_side_on(ls), .o_ref_dac(dac),
    .o_freq_code(fq), .o_soft_start_sel(ss), .o_forced_continuous_mode(fcm), .o_power_good_output(pgo),
    .o_power_good_oe(pgoe), .o_calibrating(cal), .o_hiccup(hic));
  bps_analog_model i_bps_analog_model (.i_ref_clk(clk), .i_rst_n(rst_n), .i_high_side_on(hs),
    .i_power_good_oe(pgoe), .i_forced_continuous_mode_wired(wired), .o_pwm_set(pwm), .o_on_time_done(otd), .o_mode_high(mh));
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for one watched output; a timeout ends the run
  task wt(input int i, input logic v, input int max, output int n);
    for (n = 0; n < max && sig[i] !== v; n++) step(1);
    chk(sig[i], v);
    if (sig[i] !== v) tally_and_finish();
  endtask
  task start(input logic [1:0] code, input logic w, output int t);
    en = 1'b0;
    fbu = 1'b1;
    win_in = 1'b0;
    mcode = code;
    wired = w;
    step(4);
    en = 1'b1;
    wt(0, 1'b1, 10, k);
    wt(0, 1'b0, 5000, k);
    chk(fq, 3'h5);
    chk(ss, code);
    wt(2, 1'b1, 40000, t);
    // undervoltage held past ramp end must not trip before arming plus delay
    step(2500);
    chk(hic, 1'b0);
    fbu = 1'b0;
    win_in = 1'b1;
    chk({pgoe, fcm}, 2'b10);
    wt(4, 1'b0, 4000, k);
    chk(k >= 1000, 1'b1);
    step(8);
    chk(fcm, w);
  endtask
  task zc_run(input logic forced);
    zc = 1'b1;
    step(4);
    n_ls = 0;
    lp = 1'b0;
    // a one-cycle low-side pulse after each on-time is allowed in skip
    for (k = 0; k < 96; k++) begin
      n_ls += ls && lp;
      lp = ls;
      step(1);
    end
    zc = 1'b0;
    chk(n_ls > 0, forced);
  endtask
  task pg_fall;
    win_in = 1'b0;
    win_out = 1'b1;
    wt(4, 1'b1, 600, k);
    chk(k >= 480, 1'b1);
    win_out = 1'b0;
    win_in = 1'b1;
  endtask
  task ocl_run;
    overcurrent_limit = 1'b1;
    step(12);
    for (k = 0; k < 100 && hs !== 1'b1; k++) step(1);
    chk(hs, 1'b0);
    overcurrent_limit = 1'b0;
    wt(3, 1'b1, 100, k);
  endtask
  task uv_run;
    fbu = 1'b1;
    step(900);
    chk(hic, 1'b0);
    wt(1, 1'b1, 3000, k);
    chk({hs, ls}, 2'b00);
    wt(0, 1'b1, 60000, k);
    chk(k > 7 * (((1 << 8) + 257) >> 6) * 1000 - 1000 && k <= 7 * (((1 << 8) + 257) >> 6) * 1000, 1'b1);
  endtask
  task faults;
    lock = 1'b1;
    step(6);
    chk({hs, ls, hic, cal}, 4'h0);
    fbu = 1'b0;
    lock = 1'b0;
    wt(0, 1'b1, 10, k);
    temp = 1'b1;
    step(6);
    chk({hs, ls, cal}, 3'h0);
    temp = 1'b0;
    wt(0, 1'b1, 10, k);
  endtask
  task ov_run;
    fbo = 1'b1;
    step(6);
    chk({hs, ls}, 2'b01);
    fbu = 1'b1;
    step(10);
    chk({hs, ls, hic}, 3'b001);
    fbu = 1'b0;
    step(10);
    chk({hs, ls}, 2'b00);
    fbo = 1'b0;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    step(16);
    rst_n = 1'b1;
    chk(fq, 3'h3);
    start(2'h0, 1'b1, t0);
    zc_run(1'b1);
    pg_fall();
    ocl_run();
    uv_run();
    faults();
    start(2'h1, 1'b0, t1);
    chk(t1 > 2 * t0 - 2000 && t1 < 2 * t0 + 2000, 1'b1);
    zc_run(1'b0);
    ov_run();
    tally_and_finish();
  end
endmodule
bind bps_sequencer bps_sequencer_sva #(.DAC_W(DAC_W), .CAL_TICKS(CAL_TICKS)) i_bps_sequencer_sva (.*);
`default_nettype wire
